/* File: hdl/startup_ctrl.sv */
// Purpose: startup straps, reset pin, host control lines and uart bridge
// Assumes: APB slave with one wait state, pins synchronised on pclk
// Notes:   every top output comes from a flip-flop
`timescale 1ns/1ns
`default_nettype none
`include "startup_cfg.svh"
module startup_ctrl
    import startup_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = `HOLD_TIME_S * `CLK_FREQ_HZ
)
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // control pins
    input  wire logic        rst_pin_n,
    input  wire logic        switch1_n,
    input  wire logic        switch2_n,
    input  wire logic        mode_ctl_n,
    output var  logic        state_ind_n,
    // primary uart pins
    input  wire logic        prim_rxd,
    output var  logic        prim_txd,
    input  wire logic        prim_cts_n,
    output var  logic        prim_rts_n,
    // secondary uart pins and routing
    input  wire logic        sec_rxd,
    output var  logic        sec_txd,
    input  wire logic        sec_cts_n,
    output var  logic        sec_rts_n,
    output var  logic [23:0] sec_pin_sel,
    // internal uart side
    input  wire logic        core_txd,
    input  wire logic        core_rts_n,
    output var  logic        core_rxd,
    output var  logic        core_cts_n,
    // link status from the radio stack
    input  wire logic        data_mode,
    input  wire logic        sps_pending,
    input  wire logic        sps_connected,
    input  wire logic        bonded_connected,
    input  wire logic        gap_connected,
    // system requests
    output var  logic        sys_rst_n,
    output var  logic        boot_mode,
    output var  logic        uart_restore,
    output var  logic        factory_restore,
    output var  logic        connect_req,
    output var  logic        cmd_mode_req,
    output var  logic        disconnect_req,
    output var  logic        connectable,
    output var  logic        uart_en,
    output var  logic        sleep_req
);
    import startup_pkg::*;

    localparam int IX_RST = 0;
    localparam int IX_SW1 = 1;
    localparam int IX_SW2 = 2;
    localparam int IX_DSR = 3;
    localparam int IX_PRX = 4;
    localparam int IX_PCT = 5;
    localparam int IX_SRX = 6;
    localparam int IX_SCT = 7;

    logic [7:0]  sync1_r;
    logic [7:0]  sync2_r;
    logic [5:0]  ctrl_r;
    logic [23:0] pinmap_r;
    logic        urst_seen_r;
    logic        frst_seen_r;
    logic        dsr_prev_r;
    logic [31:0] rd_val;
    logic [31:0] status_val;
    logic        rd_hit;
    logic        acc_first;
    logic        wr_take;
    logic        dsr_on;
    logic        dsr_edge;
    logic        bridge;
    logic        ind_src;
    dsr_func_t   dsr_func;
    ind_sel_t    ind_sel;

    strap_if sif ();

    strap_hold #(.HOLD_CYCLES(HOLD_CYCLES)) u_strap (
        .pclk    (pclk),
        .presetn (presetn),
        .sif     (sif.strap)
    );

    // pick the condition shown on the state output
    function automatic logic ind_pick(input ind_sel_t sel,
                                      input logic mode,
                                      input logic serial_port_emulation_service,
                                      input logic bonded,
                                      input logic gap);
        case (sel)
            IND_SYS_MODE:  ind_pick = mode;
            IND_SPS_PEERS: ind_pick = serial_port_emulation_service;
            IND_BONDED:    ind_pick = bonded;
            default:       ind_pick = gap;
        endcase
    endfunction

    // two-stage synchroniser for every pin input, idle high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= 8'hFF;
            sync2_r <= 8'hFF;
        end
        else
        begin
            sync1_r <= {sec_cts_n, sec_rxd, prim_cts_n, prim_rxd,
                        mode_ctl_n, switch2_n, switch1_n, rst_pin_n};
            sync2_r <= sync1_r;
        end
    end

    // feed the strap sequencer
    assign sif.sw1_n   = sync2_r[IX_SW1];
    assign sif.sw2_n   = sync2_r[IX_SW2];
    assign sif.restart = !sync2_r[IX_RST];
    assign boot_mode       = sif.boot_mode;
    assign uart_restore    = sif.uart_restore;
    assign factory_restore = sif.factory_restore;
    assign connect_req     = sif.connect_req;

    assign dsr_func = dsr_func_t'(ctrl_r[`CTRL_DSR_MSB:`CTRL_DSR_LSB]);
    assign ind_sel  = ind_sel_t'(ctrl_r[`CTRL_IND_MSB:`CTRL_IND_LSB]);
    assign bridge   = ctrl_r[`CTRL_BRIDGE_BIT];
    assign dsr_on   = !sync2_r[IX_DSR];
    assign dsr_edge = dsr_on && !dsr_prev_r;
    assign ind_src  = ind_pick(ind_sel, data_mode, sps_connected,
                               bonded_connected, gap_connected);

    // apb strobes: first access cycle builds the answer, next one takes it
    assign acc_first = psel && penable && !pready;
    assign wr_take   = psel && penable && pready && pwrite;

    // status view; link state is the emulated serial service only
    always_comb
    begin
        status_val                   = 32'h0;
        status_val[`STAT_BOOT_BIT]   = sif.boot_mode;
        status_val[`STAT_URST_BIT]   = urst_seen_r;
        status_val[`STAT_FRST_BIT]   = frst_seen_r;
        status_val[`STAT_CONN_BIT]   = connectable;
        status_val[`STAT_UEN_BIT]    = uart_en;
        status_val[`STAT_SLEEP_BIT]  = sleep_req;
        status_val[`STAT_PEND_BIT]   = sps_pending;
        status_val[`STAT_LINK_BIT]   = sps_connected;
        status_val[`STAT_IND_BIT]    = !state_ind_n;
    end

    // read decode
    always_comb
    begin
        rd_val = 32'h0;
        rd_hit = 1'b1;
        if (paddr == `ADDR_CTRL)
            rd_val = {26'h0, ctrl_r};
        else if (paddr == `ADDR_STATUS)
            rd_val = status_val;
        else if (paddr == `ADDR_PINMAP)
            rd_val = {8'h00, pinmap_r};
        else
            rd_hit = 1'b0;
    end

    // apb answer: one wait state, error on unmapped address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= acc_first;
            if (acc_first)
            begin
                prdata  <= pwrite ? 32'h0 : rd_val;
                pslverr <= !rd_hit;
            end
        end
    end

    // writable registers, cleared again by the reset pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r   <= `CTRL_RESET;
            pinmap_r <= `PINMAP_RESET;
        end
        else if (sif.restart)
        begin
            ctrl_r   <= `CTRL_RESET;
            pinmap_r <= `PINMAP_RESET;
        end
        else if (wr_take && paddr == `ADDR_CTRL)
            ctrl_r <= pwdata[5:0];
        else if (wr_take && paddr == `ADDR_PINMAP)
            pinmap_r <= pwdata[23:0];
    end

    // sticky restore flags, write one to clear, a new event wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            urst_seen_r <= 1'b0;
            frst_seen_r <= 1'b0;
        end
        else
        begin
            if (sif.uart_restore)
                urst_seen_r <= 1'b1;
            else if (wr_take && paddr == `ADDR_STATUS
                     && pwdata[`STAT_URST_BIT])
                urst_seen_r <= 1'b0;
            if (sif.factory_restore)
                frst_seen_r <= 1'b1;
            else if (wr_take && paddr == `ADDR_STATUS
                     && pwdata[`STAT_FRST_BIT])
                frst_seen_r <= 1'b0;
        end
    end

    // mode-control line as configured command input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dsr_prev_r     <= 1'b0;
            cmd_mode_req   <= 1'b0;
            disconnect_req <= 1'b0;
            connectable    <= 1'b1;
            uart_en        <= 1'b1;
            sleep_req      <= 1'b0;
        end
        else
        begin
            dsr_prev_r     <= dsr_on;
            cmd_mode_req   <= dsr_edge && dsr_func == DSR_CMD_MODE;
            disconnect_req <= dsr_edge && dsr_func == DSR_DISCONNECT;
            if (sif.restart)
                connectable <= 1'b1;
            else if (dsr_edge && dsr_func == DSR_DISCONNECT)
                connectable <= !connectable;
            uart_en   <= (dsr_func == DSR_UART_GATE) ? dsr_on : 1'b1;
            sleep_req <= (dsr_func == DSR_SLEEP) && dsr_on;
        end
    end

    // state indication output, active low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ind_n <= 1'b1;
            sys_rst_n   <= 1'b0;
        end
        else
        begin
            state_ind_n <= !ind_src;
            sys_rst_n   <= sync2_r[IX_RST];
        end
    end

    // uart paths: fixed primary pins, bridge to the secondary uart
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prim_txd    <= 1'b1;
            prim_rts_n  <= 1'b1;
            sec_txd     <= 1'b1;
            sec_rts_n   <= 1'b1;
            core_rxd    <= 1'b1;
            core_cts_n  <= 1'b1;
            sec_pin_sel <= `PINMAP_RESET;
        end
        else
        begin
            sec_pin_sel <= pinmap_r;
            if (!uart_en)
            begin
                prim_txd   <= 1'b1;
                prim_rts_n <= 1'b1;
                sec_txd    <= 1'b1;
                sec_rts_n  <= 1'b1;
                core_rxd   <= 1'b1;
                core_cts_n <= 1'b1;
            end
            else if (bridge)
            begin
                sec_txd    <= sync2_r[IX_PRX];
                prim_txd   <= sync2_r[IX_SRX];
                sec_rts_n  <= sync2_r[IX_PCT];
                prim_rts_n <= sync2_r[IX_SCT];
                core_rxd   <= 1'b1;
                core_cts_n <= 1'b1;
            end
            else
            begin
                prim_txd   <= core_txd;
                prim_rts_n <= core_rts_n;
                core_rxd   <= sync2_r[IX_PRX];
                core_cts_n <= sync2_r[IX_PCT];
                sec_txd    <= 1'b1;
                sec_rts_n  <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_reset_pin: assert property (
        !sync2_r[IX_RST] |=> !sys_rst_n ##1 !boot_mode)
        else $error("reset pin low did not reset the system");
    chk_connect_normal: assert property (
        connect_req |-> $past(sif.in_normal) && $past(sif.sw2_n, 2)
            && !$past(sif.sw2_n))
        else $error("link request outside normal operation");
    chk_cmd_edge: assert property (
        dsr_edge && dsr_func == DSR_CMD_MODE && !sif.restart
            |=> cmd_mode_req ##1 !cmd_mode_req)
        else $error("mode line did not request command mode");
    chk_ind_follow: assert property (
        ##1 state_ind_n == !$past(ind_src))
        else $error("state output not the chosen condition");
    chk_uart_gate: assert property (
        !uart_en |=> prim_txd && prim_rts_n)
        else $error("primary uart active while gated off");
    chk_bridge_fwd: assert property (
        bridge && uart_en |=> sec_txd == $past(sync2_r[IX_PRX])
            && core_rxd)
        else $error("bridge did not forward primary receive data");
    chk_sec_flow: assert property (
        bridge && uart_en |=> sec_rts_n == $past(sync2_r[IX_PCT]))
        else $error("secondary flow control not bridged");
    chk_sps_status: assert property (
        acc_first && !pwrite && paddr == `ADDR_STATUS
            |=> prdata[`STAT_LINK_BIT] == $past(sps_connected)
            && prdata[`STAT_PEND_BIT] == $past(sps_pending))
        else $error("link status not from emulated serial service");
    cov_bridge_on:   cover property (bridge && uart_en && !sec_txd);
    cov_sleep_entry: cover property ($rose(sleep_req));
    cov_apb_error:   cover property (pready && pslverr);
endmodule
`default_nettype wire

/* File: hdl/startup_cfg.svh */
// Purpose: constants of the startup strap and host control block
// Assumes: 32-bit APB data, 12-bit byte address
// Notes:   offsets, field positions, reset values, timing figures
`ifndef STARTUP_CFG_SVH
`define STARTUP_CFG_SVH

// register byte offsets
`define ADDR_CTRL        12'h000
`define ADDR_STATUS      12'h004
`define ADDR_PINMAP      12'h008

// control register fields
`define CTRL_BRIDGE_BIT  0
`define CTRL_DSR_LSB     1
`define CTRL_DSR_MSB     3
`define CTRL_IND_LSB     4
`define CTRL_IND_MSB     5
`define CTRL_RESET       6'h00

// status register fields
`define STAT_BOOT_BIT    0
`define STAT_URST_BIT    1
`define STAT_FRST_BIT    2
`define STAT_CONN_BIT    3
`define STAT_UEN_BIT     4
`define STAT_SLEEP_BIT   5
`define STAT_PEND_BIT    6
`define STAT_LINK_BIT    7
`define STAT_IND_BIT     8

// secondary uart pin map: four 6-bit pin numbers rxd, txd, cts, rts
`define PINMAP_RESET     24'h000000

// timing: hold time in seconds, clock rate in hertz
`define HOLD_TIME_S      10
`define CLK_FREQ_HZ      10000000
// cycles that the strap sequencer waits after a release before it samples the switches
`define SETTLE_CYCLES    2'h3

`endif

/* File: hdl/startup_pkg.sv */
// Purpose: types of the startup strap and host control block
// Assumes: nothing beyond the cfg header
// Notes:   codes of the enums count up from zero in declaration order
package startup_pkg;

    // function of the mode-control input
    typedef enum logic [2:0] {
        DSR_NONE,
        DSR_CMD_MODE,
        DSR_DISCONNECT,
        DSR_UART_GATE,
        DSR_SLEEP
    } dsr_func_t;

    // condition shown on the state indication output
    typedef enum logic [1:0] {
        IND_SYS_MODE,
        IND_SPS_PEERS,
        IND_BONDED,
        IND_GAP
    } ind_sel_t;

    // startup strap sequencer states
    typedef enum logic [1:0] {
        ST_SETTLE,
        ST_NORMAL,
        ST_BOOT_HOLD,
        ST_BOOT
    } strap_state_t;

endpackage

/* File: hdl/strap_if.sv */
// Purpose: carrier between the top block and the strap sequencer
// Assumes: one clock domain
// Notes:   switch levels arrive already synchronised
`timescale 1ns/1ns
`default_nettype none
interface strap_if;
    logic sw1_n;
    logic sw2_n;
    logic restart;
    logic boot_mode;
    logic uart_restore;
    logic factory_restore;
    logic connect_req;
    logic in_normal;

    modport ctrl (output sw1_n, sw2_n, restart,
                  input  boot_mode, uart_restore, factory_restore,
                         connect_req, in_normal);
    modport strap (input  sw1_n, sw2_n, restart,
                   output boot_mode, uart_restore, factory_restore,
                          connect_req, in_normal);
endinterface
`default_nettype wire

/* File: hdl/strap_hold.sv */
// Purpose: samples the two switches at startup and times the long hold
// Assumes: switch levels synchronised, restart high while reset pin low
// Notes:   outputs registered except in_normal, decoded from the state
`timescale 1ns/1ns
`default_nettype none
`include "startup_cfg.svh"
module strap_hold
    import startup_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = `HOLD_TIME_S * `CLK_FREQ_HZ
)
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // link to the top block
    strap_if.strap    sif
);
    import startup_pkg::*;

    strap_state_t state_r;
    logic [1:0]   settle_r;
    logic [31:0]  hold_cnt_r;
    logic         sw2_prev_r;
    logic         both_low;

    assign both_low = !sif.sw1_n && !sif.sw2_n;

    // strap sequencer: sample once, then hold timer or normal run
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r              <= ST_SETTLE;
            settle_r             <= 2'h0;
            hold_cnt_r           <= 32'h0;
            sw2_prev_r           <= 1'b1;
            sif.boot_mode        <= 1'b0;
            sif.uart_restore     <= 1'b0;
            sif.factory_restore  <= 1'b0;
            sif.connect_req      <= 1'b0;
        end
        else
        begin
            sif.uart_restore    <= 1'b0;
            sif.factory_restore <= 1'b0;
            sif.connect_req     <= 1'b0;
            sw2_prev_r          <= sif.sw2_n;
            if (sif.restart)
            begin
                state_r       <= ST_SETTLE;
                settle_r      <= 2'h0;
                sif.boot_mode <= 1'b0;
            end
            else
            begin
                case (state_r)
                    ST_SETTLE:
                    begin
                        // one sample at the end of the settle time
                        if (settle_r != `SETTLE_CYCLES)
                            settle_r <= settle_r + 2'h1;
                        else if (both_low)
                        begin
                            sif.boot_mode <= 1'b1;
                            hold_cnt_r    <= 32'h0;
                            state_r       <= ST_BOOT_HOLD;
                        end
                        else
                        begin
                            sif.uart_restore <= !sif.sw2_n;
                            state_r          <= ST_NORMAL;
                        end
                    end
                    ST_BOOT_HOLD:
                    begin
                        if (!both_low)
                            state_r <= ST_BOOT;
                        else if (hold_cnt_r == HOLD_CYCLES - 1)
                        begin
                            sif.factory_restore <= 1'b1;
                            sif.boot_mode       <= 1'b0;
                            state_r             <= ST_NORMAL;
                        end
                        else
                            hold_cnt_r <= hold_cnt_r + 32'h1;
                    end
                    ST_NORMAL:
                    begin
                        // falling edge of switch 2 opens a link
                        sif.connect_req <= sw2_prev_r && !sif.sw2_n;
                    end
                    default:
                        state_r <= state_r; // bootloader until restart
                endcase
            end
        end
    end

    assign sif.in_normal = (state_r == ST_NORMAL);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_restore_sample: assert property (
        sif.uart_restore |-> $past(state_r) == ST_SETTLE
            && $past(sif.sw2_n) == 1'b0 && $past(sif.sw1_n) == 1'b1)
        else $error("uart restore without switch 2 strap");
    chk_boot_entry: assert property (
        $rose(sif.boot_mode) |-> $past(both_low)
            && $past(state_r) == ST_SETTLE)
        else $error("boot mode entered without both switches low");
    chk_factory_hold: assert property (
        sif.factory_restore |-> $past(hold_cnt_r) == HOLD_CYCLES - 1
            && !sif.boot_mode)
        else $error("factory restore before hold time");
    chk_hold_cancel: assert property (
        state_r == ST_BOOT_HOLD && !both_low && !sif.restart
            |=> state_r == ST_BOOT && !sif.factory_restore)
        else $error("released switches did not cancel restore");
    cov_boot_entry:   cover property (state_r == ST_BOOT_HOLD);
    cov_factory_done: cover property (sif.factory_restore);
endmodule
`default_nettype wire

/* File: verif/host_model.sv */
// Purpose: host controller model on the control pins and primary uart
// Assumes: one clock; pins change just after a rising edge
// Notes:   released pins and an idle uart line sit high
`timescale 1ns/1ns
`default_nettype none
module host_model
(
    // clock
    input  wire logic pclk,
    // pins toward the block
    output var  logic rst_pin_n,
    output var  logic switch1_n,
    output var  logic switch2_n,
    output var  logic mode_ctl_n,
    output var  logic prim_rxd,
    output var  logic prim_cts_n
);
    // everything released at time zero
    initial
    begin
        {rst_pin_n, switch1_n, switch2_n, mode_ctl_n} = 4'hF;
        {prim_rxd, prim_cts_n} = 2'h3;
    end
    // reset pin, straps and mode line, then hold them stable
    task automatic pins(input logic r, s1, s2, m);
        @(posedge pclk);
        rst_pin_n  <= r;
        switch1_n  <= s1;
        switch2_n  <= s2;
        mode_ctl_n <= m;
        repeat (12) @(posedge pclk);
    endtask
    // one uart bit with flow control following it
    task automatic bit_out(input logic v);
        @(posedge pclk);
        prim_rxd   <= v;
        prim_cts_n <= ~v;
        repeat (8) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

/* File: verif/startup_strap_and_host_control_tb.sv */
// Purpose: self-checking bench of the strap and host control block
// Assumes: host model drives control and primary uart pins, bench drives apb, status, secondary and core uart
// Notes:   hold count shortened to 40 cycles
`timescale 1ns/1ns
`default_nettype none
`include "startup_cfg.svh"
module startup_strap_and_host_control_tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, pready, pslverr, serr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [23:0] sec_pin_sel;
    logic [3:0]  st = 4'h0;
    logic        sps_pending = 1'b0, sec_rxd = 1'b1, sec_cts_n = 1'b1;
    logic        core_txd = 1'b1, core_rts_n = 1'b1;
    logic        rst_pin_n, switch1_n, switch2_n, mode_ctl_n, prim_rxd;
    logic        prim_cts_n, state_ind_n, prim_txd, prim_rts_n, sec_txd;
    logic        sec_rts_n, core_rxd, core_cts_n, sys_rst_n, boot_mode;
    logic        uart_restore, factory_restore, connect_req, cmd_mode_req;
    logic        disconnect_req, connectable, uart_en, sleep_req;
    int          n_errors = 0, checks_done = 0, n_cmd = 0, n_disc = 0;
    int          n_conn = 0, n_urst = 0, n_fac = 0;
    logic [9:0]  frame = {1'b1, 8'hA5, 1'b0};

    host_model h (.pclk, .rst_pin_n, .switch1_n, .switch2_n, .mode_ctl_n,
        .prim_rxd, .prim_cts_n);
    startup_ctrl #(.HOLD_CYCLES(40)) i_dut (.pclk, .presetn, .paddr,
        .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .rst_pin_n, .switch1_n, .switch2_n, .mode_ctl_n, .state_ind_n,
        .prim_rxd, .prim_txd, .prim_cts_n, .prim_rts_n, .sec_rxd,
        .sec_txd, .sec_cts_n, .sec_rts_n, .sec_pin_sel, .core_txd,
        .core_rts_n, .core_rxd, .core_cts_n, .data_mode(st[0]),
        .sps_pending, .sps_connected(st[1]), .bonded_connected(st[2]),
        .gap_connected(st[3]), .sys_rst_n, .boot_mode, .uart_restore,
        .factory_restore, .connect_req, .cmd_mode_req, .disconnect_req,
        .connectable, .uart_en, .sleep_req);

    // clock
    always #50 pclk = ~pclk;
    // count one-cycle request pulses
    always @(posedge pclk)
    begin
        n_cmd  <= n_cmd + int'(cmd_mode_req);
        n_disc <= n_disc + int'(disconnect_req);
        n_conn <= n_conn + int'(connect_req);
        n_urst <= n_urst + int'(uart_restore);
        n_fac  <= n_fac + int'(factory_restore);
    end

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // compare one value
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // one apb transfer, read data into q and error into serr
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 16)
        begin
            n_errors++;
            give_verdict();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // main sequence
    initial
    begin
        cyc(12);
        presetn <= 1'b1;
        cyc(12);
        apb(0, `ADDR_STATUS, 0);
        chk(q, 32'h18);
        apb(0, 12'h00C, 0);
        chk(serr, 1);
        chk(q, 0);
        apb(1, `ADDR_PINMAP, 32'h1C6144);
        cyc(2);
        chk(sec_pin_sel, 24'h1C6144);
        for (int i = 0; i < 4; i++)
        begin
            apb(1, `ADDR_CTRL, i << 4);
            st <= 4'h1 << i;
            cyc(4);
            chk(state_ind_n, 0);
            st <= ~(4'h1 << i);
            cyc(4);
            chk(state_ind_n, 1);
        end
        sps_pending <= 1'b1;
        st <= 4'h8;
        apb(0, `ADDR_STATUS, 0);
        chk(q[7:6], 2'b01);
        apb(1, `ADDR_CTRL, 32'h1);
        for (int j = 0; j < 10; j++)
        begin
            {sec_rxd, sec_cts_n} <= {~frame[j], frame[j]};
            h.bit_out(frame[j]);
            chk({sec_txd, sec_rts_n}, {frame[j], ~frame[j]});
            chk({prim_txd, prim_rts_n}, {~frame[j], frame[j]});
        end
        {sec_rxd, sec_cts_n} <= 2'b11;
        apb(1, `ADDR_CTRL, 32'h2);
        h.pins(1, 1, 1, 0);
        chk(n_cmd, 1);
        {core_txd, core_rts_n} <= 2'b00;
        h.bit_out(0);
        chk({prim_txd, prim_rts_n, core_rxd, core_cts_n}, 4'h1);
        {core_txd, core_rts_n} <= 2'b11;
        apb(1, `ADDR_CTRL, 32'h4);
        h.pins(1, 1, 1, 1);
        h.pins(1, 1, 1, 0);
        chk({n_disc[3:0], connectable}, 5'h02);
        apb(1, `ADDR_CTRL, 32'h7);
        h.pins(1, 1, 1, 1);
        h.bit_out(0);
        chk({uart_en, sec_txd}, 2'b01);
        h.bit_out(1);
        h.pins(1, 1, 1, 0);
        chk(uart_en, 1);
        apb(1, `ADDR_CTRL, 32'h8);
        cyc(6);
        chk(sleep_req, 1);
        h.pins(1, 1, 1, 1);
        chk(sleep_req, 0);
        h.pins(1, 1, 0, 1);
        chk(n_conn, 1);
        h.pins(0, 1, 0, 1);
        chk(sys_rst_n, 0);
        h.pins(1, 1, 0, 1);
        chk({sys_rst_n, n_urst[3:0], n_conn[3:0]}, 9'h111);
        apb(0, `ADDR_STATUS, 0);
        chk(q[1], 1);
        apb(0, `ADDR_CTRL, 0);
        chk(q, 0);
        h.pins(0, 0, 0, 1);
        h.pins(1, 0, 0, 1);
        chk({boot_mode, n_fac[3:0]}, 5'h10);
        cyc(40);
        chk({boot_mode, n_fac[3:0]}, 5'h01);
        h.pins(0, 0, 0, 1);
        h.pins(1, 0, 0, 1);
        h.pins(1, 1, 1, 1);
        cyc(60);
        chk({boot_mode, n_fac[3:0]}, 5'h11);
        give_verdict();
    end
endmodule
`default_nettype wire
